// [include/sentence_pkg.sv]
// Shared constants and types of the cell voltage and temperature sentence framer.
package sentence_pkg;

  // ----------------------------------------------------------------
  // Clock and period timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int PERIOD_UNIT_NS = 1_000_000;
  localparam int UNIT_CYCLES = PERIOD_UNIT_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Field widths and sentence layout
  // ----------------------------------------------------------------
  localparam int CELL_IDX_W = 16;
  localparam int PERIOD_W = 16;
  localparam logic [3:0] GROUP_MAX = 4'h8;
  localparam logic [2:0] NAME_LEN = 3'h3;
  localparam logic [2:0] FIELDS_SUM = 3'h6;
  localparam logic [2:0] FIELDS_DET = 3'h4;
  localparam logic [2:0] FLD_ARRAY = 3'h3;
  localparam logic [2:0] DIG_STRING = 3'h2;
  localparam logic [2:0] DIG_INDEX = 3'h4;
  localparam logic [2:0] DIG_SIZE = 3'h2;
  localparam logic [2:0] DIG_COUNT = 3'h4;
  localparam logic [2:0] DIG_VOLT = 3'h2;
  localparam logic [2:0] DIG_TOTAL = 3'h4;
  localparam logic [1:0] DIG_BYTE_LAST = 2'h1;
  localparam logic [1:0] DIG_CHECK_LAST = 2'h1;

  // ----------------------------------------------------------------
  // Scaling of the transmitted values (decoding side reference)
  // ----------------------------------------------------------------
  localparam int TEMP_OFFSET_C = -100;
  localparam int VOLT_OFFSET = 200;

  // ----------------------------------------------------------------
  // ASCII characters
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_B = 8'h42;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_V = 8'h56;
  localparam logic [7:0] CH_1 = 8'h31;
  localparam logic [7:0] CH_2 = 8'h32;
  localparam logic [7:0] CH_4 = 8'h34;
  localparam logic [7:0] CH_DIGIT0 = 8'h30;
  localparam logic [7:0] CH_ALPHA_BASE = 8'h37;
  localparam logic [3:0] NIB_TEN = 4'hA;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {K_SUM, K_TDET, K_VDET} kind_t;
  typedef enum logic [2:0] {P_IDLE, P_NAME, P_SEP, P_VAL, P_ARR, P_CK, P_CR, P_LF} phase_t;

endpackage : sentence_pkg

// [verilog/hex_ascii.sv]
// Nibble to upper case ASCII hex digit converter.
`timescale 1ns/1ps

module hex_ascii (
  // Nibble in
  input wire logic [3:0] nibble,
  // Character out
  output logic [7:0] ascii
);
  import sentence_pkg::*;

  // Digits and letters sit in two separate ranges of the character set.
  always_comb begin
    if (nibble < NIB_TEN) begin
      ascii = CH_DIGIT0 + {4'h0, nibble};
    end else begin
      ascii = CH_ALPHA_BASE + {4'h0, nibble};
    end
  end

endmodule : hex_ascii

// [verilog/period_timer.sv]
// Millisecond period timer that raises the periodic summary send.
`timescale 1ns/1ps

module period_timer #(
  parameter int UNIT_CYCLES = sentence_pkg::UNIT_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Period selection
  input wire logic sleep_mode,
  input wire logic [sentence_pkg::PERIOD_W-1:0] active_period_ms,
  input wire logic [sentence_pkg::PERIOD_W-1:0] sleep_period_ms,
  // Period pulse
  output logic period_pulse
);
  import sentence_pkg::*;

  logic [31:0] div_cnt;
  logic [PERIOD_W-1:0] unit_cnt;
  logic unit_tick;
  logic [PERIOD_W-1:0] period_sel;

  assign period_sel = sleep_mode ? sleep_period_ms : active_period_ms;

  // Divider down to one enable pulse per millisecond.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_cnt <= 32'h0000_0000;
      unit_tick <= 1'b0;
    end else if (div_cnt == 32'(UNIT_CYCLES - 1)) begin
      div_cnt <= 32'h0000_0000;
      unit_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 32'h0000_0001;
      unit_tick <= 1'b0;
    end
  end

  // A period of zero stops periodic sending; a shortened period takes effect at once.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      unit_cnt <= '0;
      period_pulse <= 1'b0;
    end else begin
      period_pulse <= 1'b0;
      if (period_sel == '0) begin
        unit_cnt <= '0;
      end else if (unit_tick) begin
        if (unit_cnt >= period_sel - 1'b1) begin
          unit_cnt <= '0;
          period_pulse <= 1'b1;
        end else begin
          unit_cnt <= unit_cnt + 1'b1;
        end
      end
    end
  end

endmodule : period_timer

// [verilog/cell_sentence_framer.sv]
// Framer for the cell temperature detail, voltage summary and voltage detail sentences.
`timescale 1ns/1ps

// Notes on behaviour
// - Temperature detail only on question-mark request.
// - Voltage detail only on question-mark request.
// - Each group holds one to eight cells.
// - No cell link: all data fields empty.
// - First field is string index, zero single.
// - Second field first cell, numbered pack-wide.
// - Third field is group size hex.
// - Temperature bytes, one per cell, minus hundred.
// - Voltage bytes, one per cell, plus two hundred.
// - Summary sent periodically, active and sleep periods.
// - Summary also sent on question-mark request.
// - Summary field one is detected cell count.
// - Fields two to four min max average.
// - Field five is total voltage, centivolts.
// - Sixth summary field always empty.
module cell_sentence_framer #(
  parameter int UNIT_CYCLES = sentence_pkg::UNIT_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Parsed request sentences, one-cycle pulses
  input wire logic req_temp_detail,
  input wire logic req_volt_summary,
  input wire logic req_volt_detail,
  // Period configuration
  input wire logic sleep_mode,
  input wire logic [sentence_pkg::PERIOD_W-1:0] active_period_ms,
  input wire logic [sentence_pkg::PERIOD_W-1:0] sleep_period_ms,
  // Pack state
  input wire logic link_ok,
  input wire logic [sentence_pkg::CELL_IDX_W-1:0] cell_count,
  input wire logic [sentence_pkg::CELL_IDX_W-1:0] string_cells,
  input wire logic [7:0] min_volt,
  input wire logic [7:0] max_volt,
  input wire logic [7:0] avg_volt,
  input wire logic [15:0] total_volt,
  // Per-cell read port
  output logic [sentence_pkg::CELL_IDX_W-1:0] cell_addr,
  input wire logic [7:0] cell_temp,
  input wire logic [7:0] cell_volt,
  // Character stream out
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  // Status
  output logic busy
);
  import sentence_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  phase_t phase;
  kind_t kind;
  logic [2:0] fidx;
  logic [1:0] dig;
  logic [7:0] csum;
  logic link_snap;
  logic [CELL_IDX_W-1:0] first_cell;
  logic [CELL_IDX_W-1:0] str_end;
  logic [7:0] str_idx;
  logic [3:0] grp_size;
  logic [3:0] arr_left;
  logic pend_sum;
  logic pend_tdet;
  logic pend_vdet;
  logic period_pulse;
  logic adv;
  logic [7:0] char;
  logic [3:0] nib;
  logic [7:0] hex_char;
  logic [15:0] fval;
  logic [2:0] fdig;
  logic [2:0] nfields;
  logic [7:0] cell_byte;
  logic [CELL_IDX_W-1:0] span;
  logic [CELL_IDX_W-1:0] next_first;
  logic clr_sum;
  logic clr_tdet;
  logic clr_vdet;

  // A new character may be loaded when the output register is empty or being taken.
  assign adv = !tx_valid || tx_ready;
  assign nfields = (kind == K_SUM) ? FIELDS_SUM : FIELDS_DET;
  assign cell_byte = (kind == K_TDET) ? cell_temp : cell_volt;
  assign next_first = first_cell + {12'h000, grp_size};

  // Cells per string, clamped to the pack; zero means one string holds every cell.
  assign span = (string_cells == '0 || string_cells > cell_count) ? cell_count : string_cells;

  // Group size limited by the string end, the pack end and the group maximum.
  function automatic logic [3:0] group_size(input logic [CELL_IDX_W-1:0] first,
                                            input logic [CELL_IDX_W-1:0] send,
                                            input logic [CELL_IDX_W-1:0] count);
    logic [CELL_IDX_W-1:0] lim;
    lim = (send < count) ? send : count;
    if (lim - first >= {12'h000, GROUP_MAX}) begin
      group_size = GROUP_MAX;
    end else begin
      group_size = 4'(lim - first);
    end
  endfunction : group_size

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  period_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_period_timer (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sleep_mode(sleep_mode),
    .active_period_ms(active_period_ms),
    .sleep_period_ms(sleep_period_ms),
    .period_pulse(period_pulse)
  );

  hex_ascii u_hex_ascii (
    .nibble(nib),
    .ascii(hex_char)
  );

  // ----------------------------------------------------------------
  // Field contents
  // ----------------------------------------------------------------
  // Value and digit count of the current field; zero digits leave the field empty.
  always_comb begin
    fval = 16'h0000;
    fdig = 3'h0;
    if (link_snap) begin
      if (kind == K_SUM) begin
        case (fidx)
          3'h0: begin
            fval = cell_count;
            fdig = DIG_COUNT;
          end
          3'h1: begin
            fval = {8'h00, min_volt};
            fdig = DIG_VOLT;
          end
          3'h2: begin
            fval = {8'h00, max_volt};
            fdig = DIG_VOLT;
          end
          3'h3: begin
            fval = {8'h00, avg_volt};
            fdig = DIG_VOLT;
          end
          3'h4: begin
            fval = total_volt;
            fdig = DIG_TOTAL;
          end
          default: begin
            fdig = 3'h0;
          end
        endcase
      end else begin
        case (fidx)
          3'h0: begin
            fval = {8'h00, str_idx};
            fdig = DIG_STRING;
          end
          3'h1: begin
            fval = first_cell;
            fdig = DIG_INDEX;
          end
          3'h2: begin
            fval = {12'h000, grp_size};
            fdig = DIG_SIZE;
          end
          default: begin
            fdig = 3'h0;
          end
        endcase
      end
    end
  end

  // Next character of the sentence for the current phase.
  always_comb begin
    logic [15:0] shifted;
    shifted = 16'h0000;
    nib = 4'h0;
    char = CH_COMMA;
    case (phase)
      P_NAME: begin
        if (dig == 2'h0) begin
          char = CH_B;
        end else if (dig == 2'h1) begin
          char = (kind == K_TDET) ? CH_T : CH_V;
        end else begin
          char = (kind == K_SUM) ? CH_1 : ((kind == K_VDET) ? CH_2 : CH_4);
        end
      end
      P_VAL: begin
        shifted = fval >> {dig, 2'b00};
        nib = shifted[3:0];
        char = hex_char;
      end
      P_ARR: begin
        nib = dig[0] ? cell_byte[7:4] : cell_byte[3:0];
        char = hex_char;
      end
      P_CK: begin
        nib = dig[0] ? csum[7:4] : csum[3:0];
        char = hex_char;
      end
      P_CR: char = CH_CR;
      P_LF: char = CH_LF;
      default: char = CH_COMMA;
    endcase
  end

  // ----------------------------------------------------------------
  // Pending sends
  // ----------------------------------------------------------------
  // A request arriving as its flag is cleared still stands, so no reply is lost.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pend_sum <= 1'b0;
      pend_tdet <= 1'b0;
      pend_vdet <= 1'b0;
    end else begin
      pend_sum <= (pend_sum && !clr_sum) || req_volt_summary || period_pulse;
      pend_tdet <= (pend_tdet && !clr_tdet) || req_temp_detail;
      pend_vdet <= (pend_vdet && !clr_vdet) || req_volt_detail;
    end
  end

  // The summary goes first since it is short and periodic; details wait behind it.
  assign clr_sum = (phase == P_IDLE) && adv && pend_sum;
  assign clr_vdet = (phase == P_IDLE) && adv && !pend_sum && pend_vdet;
  assign clr_tdet = (phase == P_IDLE) && adv && !pend_sum && !pend_vdet && pend_tdet;

  // ----------------------------------------------------------------
  // Output character register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
    end else if (adv) begin
      tx_valid <= (phase != P_IDLE);
      if (phase != P_IDLE) begin
        tx_data <= char;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sentence sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      phase <= P_IDLE;
      kind <= K_SUM;
      fidx <= 3'h0;
      dig <= 2'h0;
      csum <= 8'h00;
      link_snap <= 1'b0;
      first_cell <= '0;
      str_end <= '0;
      str_idx <= 8'h00;
      grp_size <= 4'h0;
      arr_left <= 4'h0;
      cell_addr <= '0;
      busy <= 1'b0;
    end else if (adv) begin
      // The check value covers every character up to and including the last comma.
      if (phase == P_NAME || phase == P_SEP || phase == P_VAL || phase == P_ARR) begin
        csum <= csum + char;
      end
      case (phase)
        P_IDLE: begin
          if (pend_sum || pend_vdet || pend_tdet) begin
            kind <= pend_sum ? K_SUM : (pend_vdet ? K_VDET : K_TDET);
            // Link state is frozen per sentence so no sentence is half empty.
            link_snap <= link_ok && (pend_sum || cell_count != '0);
            phase <= P_NAME;
            busy <= 1'b1;
            dig <= 2'h0;
            fidx <= 3'h0;
            csum <= 8'h00;
            first_cell <= '0;
            str_idx <= 8'h00;
            str_end <= span;
            grp_size <= group_size('0, span, cell_count);
          end
        end
        P_NAME: begin
          if (dig == 2'(NAME_LEN - 3'h1)) begin
            phase <= P_SEP;
          end else begin
            dig <= dig + 2'h1;
          end
        end
        P_SEP: begin
          if (fidx == nfields) begin
            phase <= P_CK;
            dig <= DIG_CHECK_LAST;
          end else if (kind != K_SUM && fidx == FLD_ARRAY && link_snap) begin
            phase <= P_ARR;
            dig <= DIG_BYTE_LAST;
            cell_addr <= first_cell;
            arr_left <= grp_size;
          end else if (fdig != 3'h0) begin
            phase <= P_VAL;
            dig <= 2'(fdig - 3'h1);
          end else begin
            fidx <= fidx + 3'h1;
          end
        end
        P_VAL: begin
          if (dig == 2'h0) begin
            phase <= P_SEP;
            fidx <= fidx + 3'h1;
          end else begin
            dig <= dig - 2'h1;
          end
        end
        P_ARR: begin
          if (dig != 2'h0) begin
            dig <= 2'h0;
          end else if (arr_left == 4'h1) begin
            phase <= P_SEP;
            fidx <= fidx + 3'h1;
          end else begin
            cell_addr <= cell_addr + 1'b1;
            arr_left <= arr_left - 4'h1;
            dig <= DIG_BYTE_LAST;
          end
        end
        P_CK: begin
          if (dig == 2'h0) begin
            phase <= P_CR;
          end else begin
            dig <= dig - 2'h1;
          end
        end
        P_CR: phase <= P_LF;
        P_LF: begin
          // Another group follows while detected cells remain unreported.
          if (kind != K_SUM && link_snap && next_first < cell_count) begin
            phase <= P_NAME;
            dig <= 2'h0;
            fidx <= 3'h0;
            csum <= 8'h00;
            first_cell <= next_first;
            if (next_first >= str_end) begin
              str_idx <= str_idx + 8'h01;
              str_end <= str_end + span;
              grp_size <= group_size(next_first, str_end + span, cell_count);
            end else begin
              grp_size <= group_size(next_first, str_end, cell_count);
            end
          end else begin
            phase <= P_IDLE;
            busy <= 1'b0;
          end
        end
        default: phase <= P_IDLE;
      endcase
    end
  end

endmodule : cell_sentence_framer

// [testbench/framer_checker_assertions.sv]
// Concurrent checks on the ports of the sentence framer.
`timescale 1ns/1ps

module framer_checker #(
  parameter int UNIT_CYCLES = 20
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Requests and pack state
  input wire logic req_temp_detail,
  input wire logic req_volt_summary,
  input wire logic req_volt_detail,
  input wire logic link_ok,
  input wire logic [sentence_pkg::CELL_IDX_W-1:0] cell_count,
  // Cell read port and stream
  input wire logic [sentence_pkg::CELL_IDX_W-1:0] cell_addr,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic busy
);
  import sentence_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Stream framing
  // ----------------------------------------------------------------
  // A stalled character must stay put, or the sink would lose it.
  a_stall_holds_char: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("character changed while stalled");
  a_first_char_name: assert property ($rose(busy) |=> tx_valid && tx_data == CH_B)
    else $error("reply did not open with the name letter");
  a_cr_then_lf: assert property (tx_valid && tx_ready && tx_data == CH_CR |=> tx_valid && tx_data == CH_LF)
    else $error("line feed did not follow carriage return");
  a_busy_ends_lf: assert property ($fell(busy) |-> tx_data == CH_LF)
    else $error("reply ended without a line feed");
  // ----------------------------------------------------------------
  // Request response and cell walk
  // ----------------------------------------------------------------
  a_summary_starts: assert property (req_volt_summary && !busy && !tx_valid |-> ##2 busy)
    else $error("summary request not served");
  a_detail_starts: assert property ((req_temp_detail || req_volt_detail) && !busy && !tx_valid
    |-> ##3 (tx_valid && tx_data == CH_B))
    else $error("detail request not served");
  a_addr_bounded: assert property (tx_valid |-> cell_addr <= cell_count)
    else $error("cell address beyond detected cells");
  a_addr_ascends: assert property ($changed(cell_addr) |-> cell_addr == $past(cell_addr) + 1'b1 || cell_addr == '0)
    else $error("cell address did not ascend");
  c_summary: cover property (req_volt_summary ##2 busy);
  c_link_down: cover property (!link_ok && $rose(busy));
  c_stall: cover property (tx_valid && !tx_ready ##1 tx_valid && tx_ready);
endmodule : framer_checker

bind cell_sentence_framer framer_checker #(.UNIT_CYCLES(UNIT_CYCLES)) framer_checker_inst (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .req_temp_detail(req_temp_detail),
  .req_volt_summary(req_volt_summary), .req_volt_detail(req_volt_detail), .link_ok(link_ok),
  .cell_count(cell_count), .cell_addr(cell_addr), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .busy(busy)
);

// [testbench/char_sink.sv]
// Character sink standing for the display or host on the serial link.
`timescale 1ns/1ps

module char_sink (
  // Clock
  input wire logic ref_clk,
  // Character stream
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Pacing, high stalls every other cycle
  input wire logic slow
);
  string rx = "";
  initial tx_ready = 1'b0;
  // Take one character per accepting edge. CR and LF are kept as printable marks so that
  // captured text fits on one report line; an unknown character becomes a tilde.
  always @(posedge ref_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      case (tx_data)
        8'h0D: rx = {rx, "^"};
        8'h0A: rx = {rx, "|"};
        default: rx = $sformatf("%s%c", rx, (^tx_data === 1'bx) ? 8'h7E : tx_data);
      endcase
    end
    tx_ready <= #2 slow ? ~tx_ready : 1'b1;
  end
endmodule : char_sink

// [testbench/tb_top.sv]
// Self-checking testbench of the sentence framer.
`timescale 1ns/1ps

module tb_top;
  import sentence_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, slow = 1'b0, sleep_mode = 1'b0, link_ok = 1'b1;
  logic req_temp_detail = 1'b0, req_volt_summary = 1'b0, req_volt_detail = 1'b0;
  logic [PERIOD_W-1:0] active_period_ms = 16'h0000, sleep_period_ms = 16'h0000;
  logic [CELL_IDX_W-1:0] cell_count = 16'h000A, string_cells = 16'h0000, cell_addr;
  logic [7:0] min_volt = 8'h80, max_volt = 8'h90, avg_volt = 8'h88, tx_data;
  logic [15:0] total_volt = 16'h1234;
  logic tx_valid, tx_ready, busy;
  int n_fail = 0, samples_checked = 0;
  // Sentence names are built from the shared character codes, the same ones the framer sends.
  string sum_nm, vdet_nm, tdet_nm;
  // Cell bytes follow the address so every array byte is predictable.
  wire logic [7:0] cell_volt = cell_addr[7:0] + 8'h80;
  wire logic [7:0] cell_temp = cell_addr[7:0] + 8'h40;

  cell_sentence_framer #(.UNIT_CYCLES(20)) cell_sentence_framer_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .req_temp_detail(req_temp_detail),
    .req_volt_summary(req_volt_summary), .req_volt_detail(req_volt_detail), .sleep_mode(sleep_mode),
    .active_period_ms(active_period_ms), .sleep_period_ms(sleep_period_ms), .link_ok(link_ok),
    .cell_count(cell_count), .string_cells(string_cells), .min_volt(min_volt), .max_volt(max_volt),
    .avg_volt(avg_volt), .total_volt(total_volt), .cell_addr(cell_addr), .cell_temp(cell_temp),
    .cell_volt(cell_volt), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .busy(busy));
  char_sink char_sink_inst (.ref_clk(ref_clk), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .slow(slow));

  // Clock at 20 MHz.
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // Expected text
  // ----------------------------------------------------------------
  function automatic string hx(input int v, input int n);
    string s = "";
    string digs = "0123456789ABCDEF";
    for (int i = n - 1; i >= 0; i--) s = {s, digs.substr((v >> (4 * i)) & 15, (v >> (4 * i)) & 15)};
    return s;
  endfunction : hx
  // The check value sums every character up to the comma before it.
  function automatic string fin(input string body);
    int sum = 0;
    for (int i = 0; i < body.len(); i++) sum += body[i];
    return {body, hx(sum & 255, 2), "^|"};
  endfunction : fin
  function automatic string grp(input string nm, input int ss, input int ff, input int nn, input int base);
    string a = "";
    for (int i = 0; i < nn; i++) a = {a, hx(base + ff + i, 2)};
    return fin({nm, ",", hx(ss, 2), ",", hx(ff, 4), ",", hx(nn, 2), ",", a, ","});
  endfunction : grp
  function automatic string sum_s();
    return fin({sum_nm, ",", hx(cell_count, 4), ",", hx(min_volt, 2), ",", hx(max_volt, 2), ",",
      hx(avg_volt, 2), ",", hx(total_volt, 4), ",,"});
  endfunction : sum_s
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic step();
    @(posedge ref_clk);
    #2;
  endtask : step
  task automatic check_str(input string what, input string exp, input string got);
    samples_checked++;
    if (exp != got) begin
      n_fail++;
      $display("CHECK FAILED %s expected %s seen %s", what, exp, got);
    end
  endtask : check_str
  // Idle means eight quiet cycles, so a gap between queued sentences is not mistaken for the end.
  task automatic wait_idle();
    int quiet = 0;
    for (int i = 0; i < 4000 && quiet < 8; i++) begin
      step();
      quiet = (busy === 1'b0 && tx_valid === 1'b0) ? quiet + 1 : 0;
    end
    if (quiet < 8) begin
      n_fail++;
      $display("CHECK FAILED wait_idle expected idle seen busy");
      report_and_stop();
    end
  endtask : wait_idle
  task automatic pulse(input logic [2:0] r);
    {req_temp_detail, req_volt_detail, req_volt_summary} = r;
    step();
    {req_temp_detail, req_volt_detail, req_volt_summary} = 3'b000;
    step();
  endtask : pulse
  task automatic go(input logic [2:0] r);
    char_sink_inst.rx = "";
    pulse(r);
    wait_idle();
  endtask : go
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_summary();
    go(3'b001);
    check_str("summary", sum_s(), char_sink_inst.rx);
    char_sink_inst.rx = "";
    pulse(3'b001);
    repeat (4) step();
    pulse(3'b001);
    pulse(3'b001);
    wait_idle();
    check_str("repeat", {sum_s(), sum_s()}, char_sink_inst.rx);
    $display("test summary done");
  endtask : t_summary
  // Strings of six and four cells, stalling sink, all three requests in one cycle.
  task automatic t_all_strings();
    slow = 1'b1;
    string_cells = 16'h0006;
    go(3'b111);
    check_str("all", {sum_s(), grp(vdet_nm, 0, 0, 6, 'h80), grp(vdet_nm, 1, 6, 4, 'h80),
      grp(tdet_nm, 0, 0, 6, 'h40), grp(tdet_nm, 1, 6, 4, 'h40)}, char_sink_inst.rx);
    slow = 1'b0;
    string_cells = 16'h0000;
    $display("test all_strings done");
  endtask : t_all_strings
  task automatic t_single_string();
    go(3'b010);
    check_str("vdet", {grp(vdet_nm, 0, 0, 8, 'h80), grp(vdet_nm, 0, 8, 2, 'h80)},
      char_sink_inst.rx);
    go(3'b100);
    check_str("tdet", {grp(tdet_nm, 0, 0, 8, 'h40), grp(tdet_nm, 0, 8, 2, 'h40)},
      char_sink_inst.rx);
    $display("test single_string done");
  endtask : t_single_string
  task automatic t_link_down();
    link_ok = 1'b0;
    go(3'b111);
    check_str("link", {fin({sum_nm, ",,,,,,,"}), fin({vdet_nm, ",,,,,"}), fin({tdet_nm, ",,,,,"})},
      char_sink_inst.rx);
    link_ok = 1'b1;
    $display("test link_down done");
  endtask : t_link_down
  // Nothing unrequested while periods are zero, then each period, with the other set to zero, acts in its own state.
  task automatic t_periodic();
    char_sink_inst.rx = "";
    repeat (100) step();
    check_str("quiet", "", char_sink_inst.rx);
    for (int m = 0; m < 2; m++) begin
      sleep_mode = m[0];
      active_period_ms = m ? 16'h0000 : 16'h0002;
      sleep_period_ms = m ? 16'h0003 : 16'h0000;
      char_sink_inst.rx = "";
      for (int i = 0; i < 400 && busy !== 1'b1; i++) step();
      if (busy !== 1'b1) begin
        n_fail++;
        $display("CHECK FAILED periodic expected busy seen idle");
        report_and_stop();
      end
      active_period_ms = 16'h0000;
      sleep_period_ms = 16'h0000;
      wait_idle();
      check_str("periodic", sum_s(), char_sink_inst.rx.substr(0, sum_s().len() - 1));
    end
    sleep_mode = 1'b0;
    $display("test periodic done");
  endtask : t_periodic
  // Main sequence.
  initial begin
    sum_nm = $sformatf("%c%c%c", CH_B, CH_V, CH_1);
    vdet_nm = $sformatf("%c%c%c", CH_B, CH_V, CH_2);
    tdet_nm = $sformatf("%c%c%c", CH_B, CH_T, CH_4);
    repeat (8) step();
    sys_rst = 1'b0;
    step();
    t_summary();
    t_all_strings();
    t_single_string();
    t_link_down();
    t_periodic();
    report_and_stop();
  end
endmodule : tb_top
